// file: tx_framing_pkg.sv
// Purpose: Shared constants and types for the transmit framing and timing option bank
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Device register offsets are byte offsets on the link register port
package tx_framing_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;

  // ==========================================================================
  // Device registers
  // ==========================================================================
  localparam logic [7:0] REG_FRAMING_ADDR  = 8'h05;
  localparam logic [7:0] REG_TIMING_ADDR   = 8'h06;
  localparam logic [7:0] REG_FRAMING_RESET = 8'h00;
  localparam logic [7:0] REG_TIMING_RESET  = 8'h00;
  localparam logic [7:0] TIMING_LIVE_MASK  = 8'h3d;
  localparam logic [7:0] TIMING_UNUSED_VAL = 8'h00;

  // Framing and bypass fields
  localparam int BIT_PATH_CRC_PRESERVE = 7;
  localparam int BIT_ANNEX_B_RAI_MODE  = 6;
  localparam int BIT_SIG_ALIGNER_EN    = 5;
  localparam int BIT_EBIT_ZERO_OOMF    = 4;
  localparam int BIT_FRAMING_DISABLE   = 3;
  localparam int BIT_FRAME_BIT_BYPASS  = 2;
  localparam int BIT_CRC6_BYPASS       = 1;
  localparam int BIT_DATA_LINK_BYPASS  = 0;
  localparam logic [7:0] T1_ESF_ONLY_MASK = 8'h07;

  // Timing fields
  localparam int BIT_OCLK_SEL_HI       = 5;
  localparam int BIT_OCLK_SEL_LO       = 4;
  localparam int BIT_PLL_REF_HI        = 3;
  localparam int BIT_PLL_REF_LO        = 2;
  localparam int BIT_TX_ELASTIC_BYPASS = 0;

  // ==========================================================================
  // Controller registers (classic Wishbone, 32-bit words)
  // ==========================================================================
  localparam logic [7:0] WB_CMD_ADDR    = 8'h00;
  localparam logic [7:0] WB_STATUS_ADDR = 8'h04;
  localparam logic [7:0] WB_TXDATA_ADDR = 8'h08;
  localparam int CMD_WRITE_BIT   = 16;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_SFALIGN_BIT = 16;

  // ==========================================================================
  // Data path
  // ==========================================================================
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    FIFO_CLK_ATTENUATED = 2'b00,
    FIFO_CLK_TX_REF     = 2'b01,
    FIFO_CLK_INPUT      = 2'b10
  } fifo_clk_src_type;

  typedef enum logic [1:0] {
    PLL_REF_FIFO_INPUT  = 2'b00,
    PLL_REF_BACKPLANE   = 2'b01,
    PLL_REF_RECOVERED   = 2'b10,
    PLL_REF_TX_REF_IN   = 2'b11
  } pll_ref_type;

endpackage : tx_framing_pkg

// file: tx_link_if.sv
// Purpose: Carrier between the backplane controller and the option bank device
// Assumes: Both ends run on clk
// Notes:   Register port is request/acknowledge, data is valid/ready
`timescale 1ns/10ps
interface tx_link_if (
  input wire logic clk
);
  logic       regReq;
  logic       regWrite;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       regAck;
  logic [7:0] bpData;
  logic       bpValid;
  logic       bpReady;

  modport device (
    input  clk,
    input  regReq,
    input  regWrite,
    input  regAddr,
    input  regWdata,
    output regRdata,
    output regAck,
    input  bpData,
    input  bpValid,
    output bpReady
  );

  modport backplane (
    input  clk,
    output regReq,
    output regWrite,
    output regAddr,
    output regWdata,
    input  regRdata,
    input  regAck,
    output bpData,
    output bpValid,
    input  bpReady
  );
endinterface : tx_link_if

// file: fifo_buffer.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Output data is read straight from the storage flops
`timescale 1ns/10ps
module fifo_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type state_r;
  fifo_state_type state_nxt;
  logic           push;
  logic           pop;

  // ==========================================================================
  // Flags
  // ==========================================================================
  assign inReady  = (state_r.count != DEPTH[AW:0]);
  assign outValid = (state_r.count != '0);
  assign outData  = state_r.mem[state_r.rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    if (push) begin
      state_nxt.mem[state_r.wrPtr] = inData;
      state_nxt.wrPtr              = state_r.wrPtr + 1'b1;
    end
    if (pop) begin
      state_nxt.rdPtr = state_r.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      state_nxt.count = state_r.count + 1'b1;
    end else if (pop && !push) begin
      state_nxt.count = state_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule : fifo_buffer

// file: tx_framing_device.sv
// Purpose: Transmit framing/bypass and timing option registers with their decode
// Assumes: Mode and alarm inputs come from logic on clk
// Notes:   Decoded controls are registered, one cycle after the register changes
`timescale 1ns/10ps
module tx_framing_device
  import tx_framing_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              resetn,
  tx_link_if.device                              link,
  input  wire logic                              e1Mode,
  input  wire logic                              framePulseType,
  input  wire logic                              crcGenerateEnable,
  input  wire logic                              inputFramingDisable,
  input  wire logic                              outOfBasicFrame,
  input  wire logic                              crcInterworking,
  input  wire logic                              offlineOutOfFrame,
  input  wire logic                              outOfMultiframe,
  output logic                                   crcPreserve,
  output logic                                   crcRegenerate,
  output logic                                   raiSend,
  output logic                                   alignerInPath,
  output logic                                   ebitForce,
  output logic                                   ebitValue,
  output logic                                   framingGenerate,
  output logic                                   frameBitFromInput,
  output logic                                   crc6FromInput,
  output logic                                   dataLinkFromInput,
  output logic                                   elasticBypass,
  output tx_framing_pkg::fifo_clk_src_type       fifoOutClock,
  output tx_framing_pkg::pll_ref_type            pllReference,
  output logic                 [DATA_WIDTH-1:0]  txData,
  output logic                                   txValid,
  input  wire logic                              txReady
);
  import tx_framing_pkg::*;

  typedef struct packed {
    logic [7:0]            framing;
    logic [7:0]            timing;
    logic                  ack;
    logic [7:0]            rdata;
    logic                  crcPreserve;
    logic                  crcRegenerate;
    logic                  raiSend;
    logic                  alignerInPath;
    logic                  ebitForce;
    logic                  ebitValue;
    logic                  framingGenerate;
    logic                  frameBitFromInput;
    logic                  crc6FromInput;
    logic                  dataLinkFromInput;
    logic                  elasticBypass;
    fifo_clk_src_type      fifoOutClock;
    pll_ref_type           pllReference;
    logic [DATA_WIDTH-1:0] txData;
    logic                  txValid;
  } dev_state_type;

  dev_state_type         state_r;
  dev_state_type         state_nxt;
  logic                  fifoValid;
  logic [DATA_WIDTH-1:0] fifoData;
  logic                  fifoPop;
  logic                  regTake;

  // ==========================================================================
  // Backplane data buffer
  // ==========================================================================
  fifo_buffer #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_bp_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (link.bpValid),
    .inData   (link.bpData),
    .inReady  (link.bpReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  // Output stage refills when empty or when the consumer takes the word
  assign fifoPop = fifoValid & (!state_r.txValid | txReady);

  // Guard on ack keeps a still-held request from being taken twice
  assign regTake = link.regReq & !state_r.ack;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_nxt     = state_r;
    state_nxt.ack = regTake;

    // Register port
    if (regTake) begin
      if (link.regWrite) begin
        if (link.regAddr == REG_FRAMING_ADDR) begin
          state_nxt.framing = link.regWdata;
        end else if (link.regAddr == REG_TIMING_ADDR) begin
          state_nxt.timing = link.regWdata & TIMING_LIVE_MASK;
        end
        state_nxt.rdata = 8'h00;
      end else if (link.regAddr == REG_FRAMING_ADDR) begin
        state_nxt.rdata = state_r.framing;
      end else if (link.regAddr == REG_TIMING_ADDR) begin
        state_nxt.rdata = state_r.timing | TIMING_UNUSED_VAL;
      end else begin
        state_nxt.rdata = 8'h00;
      end
    end

    // Path CRC: only with identifiable CRC bits, generation on and a disable set
    state_nxt.crcPreserve = e1Mode & state_r.framing[BIT_PATH_CRC_PRESERVE]
                          & framePulseType & crcGenerateEnable
                          & (inputFramingDisable | state_r.framing[BIT_FRAMING_DISABLE]);
    state_nxt.crcRegenerate = e1Mode & crcGenerateEnable
                            & !state_nxt.crcPreserve;

    // RAI source set narrows under Annex B
    state_nxt.raiSend = e1Mode & (outOfBasicFrame
                      | (!state_r.framing[BIT_ANNEX_B_RAI_MODE]
                         & (crcInterworking | offlineOutOfFrame)));

    state_nxt.alignerInPath = !e1Mode & state_r.framing[BIT_SIG_ALIGNER_EN];

    state_nxt.ebitForce = e1Mode & outOfMultiframe;
    state_nxt.ebitValue = !state_r.framing[BIT_EBIT_ZERO_OOMF];

    state_nxt.framingGenerate = !state_r.framing[BIT_FRAMING_DISABLE];

    // Bypasses are meaningful in T1 ESF only; the controller clears them on writes outside T1 ESF
    state_nxt.frameBitFromInput = state_r.framing[BIT_FRAME_BIT_BYPASS];
    state_nxt.crc6FromInput     = !e1Mode & state_r.framing[BIT_CRC6_BYPASS];
    state_nxt.dataLinkFromInput = !e1Mode & state_r.framing[BIT_DATA_LINK_BYPASS];

    state_nxt.elasticBypass = state_r.timing[BIT_TX_ELASTIC_BYPASS];

    // FIFO output clock; upper bit wins over the lower one
    if (state_r.timing[BIT_OCLK_SEL_HI]) begin
      state_nxt.fifoOutClock = FIFO_CLK_INPUT;
    end else if (state_r.timing[BIT_OCLK_SEL_LO]) begin
      state_nxt.fifoOutClock = FIFO_CLK_TX_REF;
    end else begin
      state_nxt.fifoOutClock = FIFO_CLK_ATTENUATED;
    end

    // Cast is safe: the enum covers all four codes
    state_nxt.pllReference = pll_ref_type'(
      state_r.timing[BIT_PLL_REF_HI:BIT_PLL_REF_LO]);

    // Output stage
    if (fifoPop) begin
      state_nxt.txData  = fifoData;
      state_nxt.txValid = 1'b1;
    end else if (txReady) begin
      state_nxt.txValid = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r         <= '0;
      state_r.framing <= REG_FRAMING_RESET;
      state_r.timing  <= REG_TIMING_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.regAck       = state_r.ack;
  assign link.regRdata     = state_r.rdata;
  assign crcPreserve       = state_r.crcPreserve;
  assign crcRegenerate     = state_r.crcRegenerate;
  assign raiSend           = state_r.raiSend;
  assign alignerInPath     = state_r.alignerInPath;
  assign ebitForce         = state_r.ebitForce;
  assign ebitValue         = state_r.ebitValue;
  assign framingGenerate   = state_r.framingGenerate;
  assign frameBitFromInput = state_r.frameBitFromInput;
  assign crc6FromInput     = state_r.crc6FromInput;
  assign dataLinkFromInput = state_r.dataLinkFromInput;
  assign elasticBypass     = state_r.elasticBypass;
  assign fifoOutClock      = state_r.fifoOutClock;
  assign pllReference      = state_r.pllReference;
  assign txData            = state_r.txData;
  assign txValid           = state_r.txValid;

endmodule : tx_framing_device

// file: tx_backplane_ctrl.sv
// Purpose: Backplane controller that configures the option bank and feeds data
// Assumes: Software drives classic Wishbone on clk
// Notes:   Writes honour sel[0] only; wider lanes are ignored
`timescale 1ns/10ps
module tx_backplane_ctrl
  import tx_framing_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  tx_link_if.backplane     link,
  input  wire logic        t1EsfMode,
  output logic             superframeAlign,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck
);
  import tx_framing_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] datO;
    logic        busy;
    logic        regWrite;
    logic [7:0]  regAddr;
    logic [7:0]  regWdata;
    logic [7:0]  lastRdata;
    logic        bpValid;
    logic [7:0]  bpData;
    logic        superframe;
  } ctrl_state_type;

  ctrl_state_type state_r;
  ctrl_state_type state_nxt;
  logic           wbReq;
  logic           txStall;
  logic [7:0]     cmdData;

  assign wbReq   = wbCyc & wbStb & !state_r.ack;
  // Data writes wait while the link word is still unaccepted
  assign txStall = wbWe && (wbAdr == WB_TXDATA_ADDR) && state_r.bpValid;

  // ==========================================================================
  // Write policy on device settings
  // ==========================================================================
  always_comb begin
    cmdData = wbDatI[7:0];
    if (wbDatI[15:8] == REG_FRAMING_ADDR && !t1EsfMode) begin
      cmdData = wbDatI[7:0] & ~T1_ESF_ONLY_MASK;
    end else if (wbDatI[15:8] == REG_TIMING_ADDR) begin
      if (wbDatI[BIT_OCLK_SEL_HI]) begin
        cmdData[BIT_PLL_REF_HI:BIT_PLL_REF_LO] = PLL_REF_FIFO_INPUT;
      end else if (wbDatI[BIT_OCLK_SEL_LO]) begin
        cmdData[BIT_PLL_REF_HI:BIT_PLL_REF_LO] = PLL_REF_TX_REF_IN;
      end
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_nxt     = state_r;
    state_nxt.ack = wbReq & !txStall;

    if (wbReq && !txStall) begin
      state_nxt.datO = 32'h0000_0000;
      if (wbWe && wbSel[0]) begin
        if (wbAdr == WB_CMD_ADDR && !state_r.busy) begin
          state_nxt.busy     = 1'b1;
          state_nxt.regWrite = wbDatI[CMD_WRITE_BIT];
          state_nxt.regAddr  = wbDatI[15:8];
          state_nxt.regWdata = cmdData;
          if (wbDatI[CMD_WRITE_BIT] && wbDatI[15:8] == REG_FRAMING_ADDR) begin
            state_nxt.superframe = cmdData[BIT_SIG_ALIGNER_EN];
          end
        end else if (wbAdr == WB_TXDATA_ADDR) begin
          state_nxt.bpValid = 1'b1;
          state_nxt.bpData  = wbDatI[7:0];
        end
      end else if (!wbWe && wbAdr == WB_STATUS_ADDR) begin
        state_nxt.datO[STAT_BUSY_BIT]    = state_r.busy;
        state_nxt.datO[15:8]             = state_r.lastRdata;
        state_nxt.datO[STAT_SFALIGN_BIT] = state_r.superframe;
      end
    end

    if (state_r.busy && link.regAck) begin
      state_nxt.busy = 1'b0;
      if (!state_r.regWrite) begin
        state_nxt.lastRdata = link.regRdata;
      end
    end

    if (state_r.bpValid && link.bpReady) begin
      state_nxt.bpValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.regReq   = state_r.busy;
  assign link.regWrite = state_r.regWrite;
  assign link.regAddr  = state_r.regAddr;
  assign link.regWdata = state_r.regWdata;
  assign link.bpValid  = state_r.bpValid;
  assign link.bpData   = state_r.bpData;
  assign superframeAlign = state_r.superframe;
  assign wbAck         = state_r.ack;
  assign wbDatO        = state_r.datO;

endmodule : tx_backplane_ctrl

// file: tx_link_sva.sv
// Purpose: Protocol and register checks on the link between controller and option bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Instantiated beside the link interface in tb
`timescale 1ns/10ps
module tx_link_sva
  import tx_framing_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       regReq,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       regAck,
  input wire logic [7:0] bpData,
  input wire logic       bpValid,
  input wire logic       bpReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Register port
  // ==========================================================================
  property p_ackPulse; regAck |=> !regAck; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("link ack longer than one cycle");
  property p_ackCause; $rose(regAck) |-> $past(regReq); endproperty
  a_ackCause: assert property (p_ackCause) else $error("link ack without request");
  property p_reqHold;
    regReq && !regAck |=> regReq && $stable(regAddr) && $stable(regWdata) && $stable(regWrite);
  endproperty
  a_reqHold: assert property (p_reqHold) else $error("link request changed before ack");
  property p_answer; $rose(regReq) |-> ##[1:8] regAck; endproperty
  a_answer: assert property (p_answer) else $error("link request not answered");
  property p_unusedZero;
    regAck && !regWrite && regAddr == REG_TIMING_ADDR |-> (regRdata & ~TIMING_LIVE_MASK) == 8'h00;
  endproperty
  a_unusedZero: assert property (p_unusedZero) else $error("timing unused bits not zero");
  property p_unmapped;
    regAck && !regWrite && regAddr != REG_TIMING_ADDR && regAddr != REG_FRAMING_ADDR
      |-> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Timing writes carry the PLL reference the clock select needs
  property p_pll_reference_select;
    regReq && regWrite && regAddr == REG_TIMING_ADDR && regWdata[5:4] == 2'b01
      |-> regWdata[3:2] == 2'b11;
  endproperty
  a_pll_reference_select: assert property (p_pll_reference_select) else $error("tx ref select without PLL ref 11");
  property p_pllIn;
    regReq && regWrite && regAddr == REG_TIMING_ADDR && regWdata[5] |-> regWdata[3:2] == 2'b00;
  endproperty
  a_pllIn: assert property (p_pllIn) else $error("input clock select without PLL ref 00");
  // ==========================================================================
  // Data stream
  // ==========================================================================
  property p_bpHold; bpValid && !bpReady |=> bpValid && $stable(bpData); endproperty
  a_bpHold: assert property (p_bpHold) else $error("backplane word dropped while stalled");
endmodule : tx_link_sva

// file: tb.sv
// Purpose: Self-checking bench for controller and option bank joined by the link
// Assumes: Wishbone map of the controller, random modes from a fixed seed
// Notes:   Decoded outputs are checked against the written register values
`timescale 1ns/10ps
module tb;
  import tx_framing_pkg::*;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic clk, resetn, t1EsfMode, wbCyc, wbStb, wbWe, wbAck, superframeAlign, txValid, txReady;
  logic [7:0] wbAdr, mode, txData;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, q;
  logic crcPreserve, crcRegenerate, raiSend, alignerInPath, ebitForce, ebitValue;
  logic framingGenerate, frameBitFromInput, crc6FromInput, dataLinkFromInput, elasticBypass;
  fifo_clk_src_type fifoOutClock;
  pll_ref_type pllReference;
  int failures = 0, checks = 0, cyc = 0;
  logic [7:0] fr, tm, et, words[$];
  logic [9:0] dec;
  tx_link_if link (.clk(clk));
  tx_backplane_ctrl u_tx_backplane_ctrl (.clk(clk), .resetn(resetn), .link(link),
    .t1EsfMode(t1EsfMode), .superframeAlign(superframeAlign), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck));
  tx_framing_device u_tx_framing_device (.clk(clk), .resetn(resetn), .link(link),
    .e1Mode(mode[7]), .framePulseType(mode[6]), .crcGenerateEnable(mode[5]),
    .inputFramingDisable(mode[4]), .outOfBasicFrame(mode[3]), .crcInterworking(mode[2]),
    .offlineOutOfFrame(mode[1]), .outOfMultiframe(mode[0]), .crcPreserve(crcPreserve),
    .crcRegenerate(crcRegenerate), .raiSend(raiSend), .alignerInPath(alignerInPath),
    .ebitForce(ebitForce), .ebitValue(ebitValue), .framingGenerate(framingGenerate),
    .frameBitFromInput(frameBitFromInput), .crc6FromInput(crc6FromInput),
    .dataLinkFromInput(dataLinkFromInput), .elasticBypass(elasticBypass),
    .fifoOutClock(fifoOutClock), .pllReference(pllReference), .txData(txData),
    .txValid(txValid), .txReady(txReady));
  tx_link_sva u_tx_link_sva (.clk(clk), .resetn(resetn), .regReq(link.regReq),
    .regWrite(link.regWrite), .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regRdata(link.regRdata), .regAck(link.regAck), .bpData(link.bpData),
    .bpValid(link.bpValid), .bpReady(link.bpReady));
  // ==========================================================================
  // Clock, timeout and verdict
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // ==========================================================================
  // Wishbone master; waits on ack, never assumes a latency
  // ==========================================================================
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
    // Ack is sampled at the rising edge; only the bench timeout ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1);
    q = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
  endtask : wb
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, WB_CMD_ADDR, {15'h0, w, a, d});
    do begin
      wb(1'b0, WB_STATUS_ADDR, 32'h0);
    end while (q[STAT_BUSY_BIT] !== 1'b0);
  endtask : dev
  // Expected decode from mode inputs and framing register
  function automatic logic [9:0] expDec(logic [7:0] m, logic [7:0] f);
    logic p;
    p = m[7] & m[6] & m[5] & (m[4] | f[3]) & f[7];
    return {p, m[7] & m[5] & !p, m[7] & (m[3] | (!f[6] & (m[2] | m[1]))), !m[7] & f[5],
      m[7] & m[0], m[7] & m[0] & !f[4], !f[3], f[2], !m[7] & f[1], !m[7] & f[0]};
  endfunction : expDec
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {resetn, t1EsfMode, wbCyc, wbStb, wbWe, wbAdr, wbDatI, mode, txReady} = '0;
    wbSel = 4'hf;
    void'($urandom(32'h87290bc1));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    dev(1'b0, REG_TIMING_ADDR, 8'h0);
    `CHK("timing reset", 8'h00, q[15:8])
    dev(1'b0, REG_FRAMING_ADDR, 8'h0);
    `CHK("framing reset", REG_FRAMING_RESET, q[15:8])
    dev(1'b1, 8'h07, 8'hff);
    dev(1'b0, 8'h07, 8'h0);
    `CHK("unmapped device", 8'h00, q[15:8])
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped bus", 32'h0, q)
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      mode <= 8'($urandom);
      t1EsfMode <= (i < 2) ? i[0] : 1'($urandom);
      fr = (i < 2) ? 8'hff : 8'($urandom);
      tm = (i == 0) ? 8'h10 : (i == 1) ? 8'h20 : (i == 2) ? 8'hc2 : 8'($urandom);
      dev(1'b1, REG_FRAMING_ADDR, fr);
      if (!t1EsfMode) fr = fr & ~T1_ESF_ONLY_MASK;
      `CHK("superframe align", fr[5], q[STAT_SFALIGN_BIT])
      dev(1'b0, REG_FRAMING_ADDR, 8'h0);
      `CHK("framing readback", fr, q[15:8])
      `CHK("superframe pin", fr[5], superframeAlign)
      dec = {crcPreserve, crcRegenerate, raiSend, alignerInPath, ebitForce, ebitForce & ebitValue,
        framingGenerate, frameBitFromInput, crc6FromInput, dataLinkFromInput};
      `CHK("decode", expDec(mode, fr), dec)
      et = tm & TIMING_LIVE_MASK;
      if (et[5]) et[3:2] = 2'b00;
      else if (et[4]) et[3:2] = 2'b11;
      dev(1'b1, REG_TIMING_ADDR, tm);
      dev(1'b0, REG_TIMING_ADDR, 8'h0);
      `CHK("timing readback", et, q[15:8])
      `CHK("fifo clock", et[5] ? 2'b10 : et[5:4], fifoOutClock)
      `CHK("pll reference", et[3:2], pllReference)
      `CHK("elastic bypass", et[0], elasticBypass)
    end
    // Fill the buffer with the far side stalled, then drain with random stalls
    for (int i = 0; i < 17; i++) begin
      words.push_back(8'($urandom));
      wb(1'b1, WB_TXDATA_ADDR, {24'h0, words[i]});
    end
    repeat (3) @(posedge clk);
    `CHK("buffer full", 1'b0, link.bpReady)
    while (words.size() > 0) begin
      @(negedge clk);
      if (txValid === 1'b1 && txReady === 1'b1) `CHK("stream word", words.pop_front(), txData)
      @(posedge clk);
      txReady <= 1'($urandom);
    end
    conclude();
  end
endmodule : tb
